/* File: rtl/qios_defines.svh */
`ifndef QIOS_DEFINES_SVH
`define QIOS_DEFINES_SVH

// Clock and timing
`define QIOS_CLK_PERIOD_NS      4
`define QIOS_AUX_PERIOD_NS      10000
`define QIOS_AUX_HALF_CYCLES    (`QIOS_AUX_PERIOD_NS / 2 / `QIOS_CLK_PERIOD_NS)
`define QIOS_AUX_CNT_W          11

// Optical angle word, factor and quarter-count widths
`define QIOS_ANGLE_W            11
`define QIOS_FACTOR_W           11
`define QIOS_STATE_W            13

// Reset factor and settle count
`define QIOS_RST_FACTOR         11'h001
`define QIOS_SETTLE_CYCLES      2'h2

// Programmed index width codes
`define QIOS_PWID_90            2'h0
`define QIOS_PWID_180           2'h1
`define QIOS_PWID_360           2'h3
`endif

/* File: rtl/qios_pkg.sv */
package qios_pkg;
    // Decoded level of a three-level select pad
    typedef enum logic [1:0] {
        TRI_LOW  = 2'h0,
        TRI_HIGH = 2'h1,
        TRI_OPEN = 2'h2
    } qios_tri_t;

    // How the index pulse is shaped
    typedef enum logic [1:0] {
        IDX_90,
        IDX_180,
        IDX_360,
        IDX_RAW
    } qios_idx_mode_t;

    // Power-up sequencing
    typedef enum logic [1:0] {
        ST_CFG,
        ST_WAIT,
        ST_RUN
    } qios_state_t;
endpackage

/* File: rtl/qios_sel_if.sv */
interface qios_sel_if;
    import qios_pkg::*;
    // Settled select levels
    qios_tri_t selFirst;
    qios_tri_t selSecond;
    qios_tri_t selThird;
    qios_tri_t idxSel;
    logic      settled;      // All selects have stayed put long enough

    modport producer (output selFirst, selSecond, selThird, idxSel, settled);
    modport consumer (input selFirst, selSecond, selThird, idxSel, settled);
endinterface

/* File: rtl/qios_sel_sync.sv */
`include "qios_defines.svh"
module qios_sel_sync
    import qios_pkg::*;
(
    // Clock and reset
    input  wire logic   ref_clk,
    input  wire logic   rst,
    // Raw pad detector codes, asynchronous
    input  wire logic [7:0] rawSel,
    // Settled levels toward the output stage
    qios_sel_if.producer sel
);
    // Three-stage chain per bit, plus the accepted value
    typedef struct packed {
        logic [7:0] ff1;
        logic [7:0] ff2;
        logic [7:0] ff3;
        logic [7:0] stable;
        logic [2:0] fill;       // Marks stages that already hold real pad samples
        logic [1:0] settleCnt;
    } qios_sync_st_t;

    qios_sync_st_t s_q;
    qios_sync_st_t s_d;

    // Map a two-bit code to a level; the unused code reads as open
    function automatic qios_tri_t toTri(input logic [1:0] c);
        begin
            toTri = (c == 2'h0) ? TRI_LOW : ((c == 2'h1) ? TRI_HIGH : TRI_OPEN);
        end
    endfunction

    // Shift the chain; a field is accepted only when stages two and three agree
    always_comb
    begin
        s_d = s_q;
        s_d.ff1 = rawSel;
        s_d.ff2 = s_q.ff1;
        s_d.ff3 = s_q.ff2;
        s_d.fill = {s_q.fill[1:0], 1'b1};
        for (int i = 0; i < 4; i++)
        begin
            if (s_q.ff2[2*i +: 2] == s_q.ff3[2*i +: 2])
            begin
                s_d.stable[2*i +: 2] = s_q.ff3[2*i +: 2];
            end
        end
        // Wait for a few agreeing cycles before declaring the pads settled
        // Reset zeros in the chain agree with each other, so they must not count
        if (!s_q.fill[2] || (s_q.ff2 != s_q.ff3))
        begin
            s_d.settleCnt = 2'h0;
        end
        else if (s_q.settleCnt != `QIOS_SETTLE_CYCLES)
        begin
            s_d.settleCnt = s_q.settleCnt + 2'h1;
        end
    end

    // State register
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign sel.selFirst  = toTri(s_q.stable[1:0]);
    assign sel.selSecond = toTri(s_q.stable[3:2]);
    assign sel.selThird  = toTri(s_q.stable[5:4]);
    assign sel.idxSel    = toTri(s_q.stable[7:6]);
    assign sel.settled   = (s_q.settleCnt == `QIOS_SETTLE_CYCLES);
endmodule

/* File: rtl/qios_output_stage.sv */
`include "qios_defines.svh"
module qios_output_stage
    import qios_pkg::*;
(
    // Clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    // Three-level select pads, decoded 0 low, 1 high, 2 open
    input  wire logic [1:0]                  modeSelectFirst,
    input  wire logic [1:0]                  modeSelectSecond,
    input  wire logic [1:0]                  modeSelectThird,
    input  wire logic [1:0]                  indexGatingSelect,
    // Optical front end, same clock
    input  wire logic [`QIOS_ANGLE_W-1:0]    opticalAngle,
    input  wire logic                        rawIndex,
    // Serial engine side
    input  wire logic [`QIOS_FACTOR_W-1:0]   programmedFactor,
    input  wire logic [1:0]                  programmedIndexWidth,
    input  wire logic                        serialDataOutFromEngine,
    output logic                             serialClockToEngine,
    output logic                             serialDataInToEngine,
    output logic                             programmingActive,
    // Channel A pins
    output logic                             quadATrue,
    output logic                             quadACompOut,
    output logic                             quadACompOeN,
    input  wire logic                        quadACompIn,
    // Channel B pins
    output logic                             quadBTrue,
    output logic                             quadBCompOut,
    output logic                             quadBCompOeN,
    input  wire logic                        quadBCompIn,
    // Index pins
    output logic                             indexTrueOut,
    output logic                             indexTrueOeN,
    output logic                             indexCompOut,
    output logic                             indexCompOeN,
    // Status
    output logic                             outputsValid,
    output logic [`QIOS_FACTOR_W-1:0]        activeFactor
);
    // Settled select levels from the pad synchroniser
    qios_sel_if selBus ();

    qios_sel_sync u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .rawSel  ({indexGatingSelect, modeSelectThird, modeSelectSecond, modeSelectFirst}),
        .sel     (selBus.producer)
    );

    // All state of the stage in one record
    typedef struct packed {
        qios_state_t                 state;
        logic [`QIOS_FACTOR_W-1:0]   factor;      // Factor latched at power-up
        qios_idx_mode_t              idxMode;     // Gating latched at power-up
        logic                        serialMode;
        logic                        primed;      // First A/B sample taken
        logic                        prevA;
        logic                        prevB;
        logic [`QIOS_AUX_CNT_W-1:0]  auxCnt;
        logic                        auxClk;
        logic                        progMode;    // Serial programming in progress
        logic [2:0]                  sclkSync;
        logic [2:0]                  sdinSync;
        logic                        sclk;
        logic                        sdin;
        logic                        aT;
        logic                        aC;
        logic                        bT;
        logic                        bC;
        logic                        iT;
        logic                        iC;
        logic                        shareOe;     // Shared pins turned to serial use
    } qios_main_st_t;

    qios_main_st_t s_q;
    qios_main_st_t s_d;

    // Factor from the three selects; first steps fastest, low-high-open
    function automatic logic [`QIOS_FACTOR_W-1:0] pinFactor(
        input qios_tri_t f,
        input qios_tri_t s,
        input qios_tri_t t
    );
        logic [3:0] n;
        begin
            n = 4'(f) + 4'(3 * s);
            pinFactor = 11'h001;
            case (t)
                TRI_LOW:  pinFactor = 11'(n + 4'h1);
                TRI_HIGH:
                begin
                    case (n)
                        4'h0:    pinFactor = 11'h00a;
                        4'h1:    pinFactor = 11'h00c;
                        4'h2:    pinFactor = 11'h00e;
                        4'h3:    pinFactor = 11'h00f;
                        4'h4:    pinFactor = 11'h010;
                        4'h5:    pinFactor = 11'h012;
                        4'h6:    pinFactor = 11'h014;
                        4'h7:    pinFactor = 11'h019;
                        default: pinFactor = 11'h020;
                    endcase
                end
                default:
                begin
                    case (n)
                        4'h0:    pinFactor = 11'h032;
                        4'h1:    pinFactor = 11'h040;
                        4'h2:    pinFactor = 11'h050;
                        4'h3:    pinFactor = 11'h064;
                        4'h4:    pinFactor = 11'h080;
                        4'h5:    pinFactor = 11'h0a0;
                        4'h6:    pinFactor = 11'h100;
                        4'h7:    pinFactor = 11'h200;
                        default: pinFactor = 11'h001;          // Serial mode, unused
                    endcase
                end
            endcase
        end
    endfunction

    // Working values of the interpolator
    logic [`QIOS_FACTOR_W-1:0]   effFactor;
    qios_idx_mode_t              effIdx;
    logic [`QIOS_STATE_W+10:0]   product;
    logic [`QIOS_STATE_W-1:0]    quarter;      // Quarter-cycle count in the optical cycle
    logic [`QIOS_FACTOR_W-1:0]   cycleNum;
    logic [`QIOS_FACTOR_W-1:0]   centreCycle;
    logic                        newA;
    logic                        newB;
    logic                        newI;
    logic                        centreHit;

    // Pick the factor and index shape in force, then interpolate
    always_comb
    begin
        effFactor = s_q.factor;
        effIdx    = s_q.idxMode;
        if (s_q.serialMode)
        begin
            // A zero programmed factor would stop the outputs, so treat it as 1X
            effFactor = (programmedFactor == '0) ? `QIOS_RST_FACTOR : programmedFactor;
            case (programmedIndexWidth)
                `QIOS_PWID_180: effIdx = IDX_180;
                `QIOS_PWID_360: effIdx = IDX_360;
                default:        effIdx = IDX_90;
            endcase
        end
        // Four quarter states per output cycle, factor cycles per optical cycle
        product     = 24'(opticalAngle) * 24'({effFactor, 2'b00});
        quarter     = product[23:11];
        cycleNum    = quarter[12:2];
        centreCycle = effFactor >> 1;
        // Gray sequence 00,10,11,01 gives equal quarters and B 90 behind A
        newA        = (quarter[1:0] == 2'h1) || (quarter[1:0] == 2'h2);
        newB        = quarter[1];
        centreHit   = rawIndex && (cycleNum == centreCycle);
        case (effIdx)
            IDX_90:  newI = centreHit && (quarter[1:0] == 2'h2);
            IDX_180: newI = centreHit && quarter[1];
            IDX_360: newI = centreHit;
            default: newI = rawIndex;
        endcase
    end

    // Next-state logic
    always_comb
    begin
        s_d = s_q;
        // Pad inputs of the shared pins pass three stages before use
        s_d.sclkSync = {s_q.sclkSync[1:0], quadBCompIn};
        s_d.sdinSync = {s_q.sdinSync[1:0], quadACompIn};
        if (s_q.sclkSync[1] == s_q.sclkSync[2])
        begin
            s_d.sclk = s_q.sclkSync[2];
        end
        if (s_q.sdinSync[1] == s_q.sdinSync[2])
        begin
            s_d.sdin = s_q.sdinSync[2];
        end
        // Free-running 100 kHz auxiliary clock
        if (s_q.auxCnt == `QIOS_AUX_CNT_W'(`QIOS_AUX_HALF_CYCLES - 1))
        begin
            s_d.auxCnt = '0;
            s_d.auxClk = ~s_q.auxClk;
        end
        else
        begin
            s_d.auxCnt = s_q.auxCnt + 1'b1;
        end
        // Programming follows the live index select while in serial mode
        s_d.progMode = s_q.serialMode && (s_q.state != ST_CFG)
                      && (selBus.idxSel == TRI_LOW);
        s_d.prevA = newA;
        s_d.prevB = newB;
        case (s_q.state)
            ST_CFG:
            begin
                // Take the selects once, as soon as the pads have settled
                if (selBus.settled)
                begin
                    s_d.factor     = pinFactor(selBus.selFirst, selBus.selSecond,
                                               selBus.selThird);
                    s_d.serialMode = (selBus.selFirst == TRI_OPEN)
                                     && (selBus.selSecond == TRI_OPEN)
                                     && (selBus.selThird == TRI_OPEN);
                    case (selBus.idxSel)
                        TRI_LOW:  s_d.idxMode = IDX_90;
                        TRI_HIGH: s_d.idxMode = IDX_180;
                        default:
                        begin
                            // Open index select passes the raw index only at 1X
                            s_d.idxMode = (s_d.factor == `QIOS_RST_FACTOR)
                                          ? IDX_RAW : IDX_360;
                        end
                    endcase
                    s_d.state = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                // Outputs stay quiet until A or B first changes
                s_d.primed = 1'b1;
                if (s_q.primed && ((newA != s_q.prevA) || (newB != s_q.prevB)))
                begin
                    s_d.state = ST_RUN;
                end
            end
            ST_RUN:
            begin
                s_d.state = ST_RUN;
            end
            default:
            begin
                s_d.state = ST_CFG;
            end
        endcase
        // Drive the pins; held low before the first toggle
        if (s_d.state == ST_RUN)
        begin
            s_d.aT = newA;
            s_d.aC = ~newA;
            s_d.bT = newB;
            s_d.bC = ~newB;
            s_d.iT = newI;
            s_d.iC = ~newI;
        end
        else
        begin
            s_d.aT = 1'b0;
            s_d.aC = 1'b0;
            s_d.bT = 1'b0;
            s_d.bC = 1'b0;
            s_d.iT = 1'b0;
            s_d.iC = 1'b0;
        end
        // While programming, the shared pins take their serial roles
        s_d.shareOe = s_d.progMode;
        if (s_d.progMode)
        begin
            s_d.iT = serialDataOutFromEngine;
            s_d.iC = s_d.auxClk;
        end
    end

    // State register
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_q            <= '0;
            s_q.state      <= ST_CFG;
            s_q.factor     <= `QIOS_RST_FACTOR;
            s_q.idxMode    <= IDX_90;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Pin and status outputs from the state register, except the tied-low index enables and activeFactor in serial mode
    assign quadATrue            = s_q.aT;
    assign quadACompOut         = s_q.aC;
    assign quadACompOeN         = s_q.shareOe;   // Released to take serial data in
    assign quadBTrue            = s_q.bT;
    assign quadBCompOut         = s_q.bC;
    assign quadBCompOeN         = s_q.shareOe;   // Released to take the serial clock
    assign indexTrueOut         = s_q.iT;
    assign indexTrueOeN         = 1'b0;
    assign indexCompOut         = s_q.iC;
    assign indexCompOeN         = 1'b0;
    assign serialClockToEngine  = s_q.sclk;
    assign serialDataInToEngine = s_q.sdin;
    assign programmingActive    = s_q.progMode;
    assign outputsValid         = (s_q.state == ST_RUN);
    assign activeFactor         = s_q.serialMode ? effFactor : s_q.factor;
endmodule

/* File: sim/qios_output_stage_chk.sv */
`include "qios_defines.svh"
module qios_out_chk
(
    // Clock and reset
    input wire logic                      ref_clk,
    input wire logic                      rst,
    // Stage inputs
    input wire logic [`QIOS_ANGLE_W-1:0]  opticalAngle,
    input wire logic                      rawIndex,
    input wire logic                      serialDataOutFromEngine,
    // Pins and status
    input wire logic                      quadATrue,
    input wire logic                      quadACompOut,
    input wire logic                      quadACompOeN,
    input wire logic                      quadBTrue,
    input wire logic                      quadBCompOut,
    input wire logic                      quadBCompOeN,
    input wire logic                      indexTrueOut,
    input wire logic                      indexTrueOeN,
    input wire logic                      indexCompOut,
    input wire logic                      programmingActive,
    input wire logic                      outputsValid,
    input wire logic [`QIOS_FACTOR_W-1:0] activeFactor
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [`QIOS_ANGLE_W-1:0] angleQ;  // Angle behind the pins, one cycle of latency
    logic [23:0]              prod;    // Angle times four times factor
    logic [1:0]               qtr;     // Quarter state inside one output cycle
    logic                     normal;  // Pins valid and not serving the serial port
    // Track the angle the stage last sampled
    always_ff @(posedge ref_clk)
    begin
        angleQ <= opticalAngle;
    end
    assign prod   = 24'(angleQ) * 24'(activeFactor) * 24'h4;
    assign qtr    = prod[12:11];
    assign normal = outputsValid && !programmingActive;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    chk_a_quarter: assert property (normal && $past(normal)
        |-> quadATrue == (qtr[1] ^ qtr[0]))
        else $error("channel A off its quarter state");
    chk_b_quarter: assert property (normal && $past(normal) |-> quadBTrue == qtr[1])
        else $error("channel B off its quarter state");
    chk_comp_invert: assert property (normal |-> quadACompOut != quadATrue &&
        quadBCompOut != quadBTrue && indexCompOut != indexTrueOut)
        else $error("complement pin equals true pin");
    chk_pins_driven: assert property (!programmingActive && !$past(programmingActive)
        |-> !quadACompOeN && !quadBCompOeN && !indexTrueOeN)
        else $error("output pin not driven");
    chk_dark_start: assert property (!outputsValid && !programmingActive
        |-> !quadATrue && !quadBTrue && !indexTrueOut)
        else $error("pins active before first toggle");
    chk_valid_hold: assert property (outputsValid |=> outputsValid)
        else $error("valid flag dropped");
    chk_valid_cause: assert property ($rose(outputsValid) |-> quadATrue != quadBTrue)
        else $error("valid rose without a single channel toggle");
    chk_idx_cause: assert property (normal && indexTrueOut |-> $past(rawIndex))
        else $error("index high without optical index");
    chk_comp_release: assert property (programmingActive |-> quadACompOeN && quadBCompOeN)
        else $error("serial input pins still driven");
    chk_serial_out: assert property (programmingActive && $past(programmingActive)
        |-> indexTrueOut == $past(serialDataOutFromEngine))
        else $error("serial data out not on index pin");
endmodule
bind qios_output_stage qios_out_chk i_qios_out_chk (
    .ref_clk, .rst, .opticalAngle, .rawIndex, .serialDataOutFromEngine, .quadATrue,
    .quadACompOut, .quadACompOeN, .quadBTrue, .quadBCompOut, .quadBCompOeN, .indexTrueOut,
    .indexTrueOeN, .indexCompOut, .programmingActive, .outputsValid, .activeFactor
);

/* File: sim/qios_host_model.sv */
module qios_host_model
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Received channels
    input wire logic chA,
    input wire logic chB,
    input wire logic chI,
    // Counts since reset
    output int       edgeCnt,
    output int       jumpCnt,
    output int       idxCnt
);
    timeunit 1ns;
    timeprecision 100ps;
    logic armed;           // Lines trusted once A or B first moved
    logic aQ, bQ, iQ;      // Previous line levels
    // Decode edges; both channels moving at once is an illegal state jump
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            armed   <= 1'b0;
            edgeCnt <= 0;
            jumpCnt <= 0;
            idxCnt  <= 0;
        end
        else
        begin
            if (chA != aQ || chB != bQ)
                armed <= 1'b1;
            if (armed)
            begin
                edgeCnt <= edgeCnt + int'(chA != aQ) + int'(chB != bQ);
                jumpCnt <= jumpCnt + int'(chA != aQ && chB != bQ);
                idxCnt  <= idxCnt + int'(chI && !iQ);
            end
        end
        aQ <= chA;
        bQ <= chB;
        iQ <= chI;
    end
endmodule

/* File: sim/tb_top.sv */
`include "qios_defines.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // Stimulus, all given a value at time zero
    logic ref_clk = 1'b0, rst = 1'b1, rawIndex = 1'b0, serialDataOutFromEngine = 1'b0;
    logic [1:0] modeSelectFirst = 2'h0, modeSelectSecond = 2'h0;
    logic [1:0] modeSelectThird = 2'h0, indexGatingSelect = 2'h0;
    logic [`QIOS_ANGLE_W-1:0]  opticalAngle = '0;
    logic [`QIOS_FACTOR_W-1:0] programmedFactor = 11'h005;
    logic hostDin = 1'b0, hostClk = 1'b0;  // Host drive on the released pads
    // Stage outputs and resolved pads
    logic serialClockToEngine, serialDataInToEngine, programmingActive, outputsValid;
    logic quadATrue, quadACompOut, quadACompOeN, quadACompIn;
    logic quadBTrue, quadBCompOut, quadBCompOeN, quadBCompIn;
    logic indexTrueOut, indexTrueOeN, indexCompOut, indexCompOeN;
    logic [`QIOS_FACTOR_W-1:0] activeFactor;
    int edgeCnt, jumpCnt, idxCnt, nErrors = 0, totalChecks = 0;
    // Pad wire: the stage wins while enabled, else the host's level
    assign quadACompIn = quadACompOeN ? hostDin : quadACompOut;
    assign quadBCompIn = quadBCompOeN ? hostClk : quadBCompOut;
    qios_output_stage i_qios_output_stage (
        .ref_clk, .rst, .modeSelectFirst, .modeSelectSecond, .modeSelectThird,
        .indexGatingSelect, .opticalAngle, .rawIndex, .programmedFactor,
        .programmedIndexWidth(2'h0), .serialDataOutFromEngine, .serialClockToEngine,
        .serialDataInToEngine, .programmingActive, .quadATrue, .quadACompOut, .quadACompOeN,
        .quadACompIn, .quadBTrue, .quadBCompOut, .quadBCompOeN, .quadBCompIn, .indexTrueOut,
        .indexTrueOeN, .indexCompOut, .indexCompOeN, .outputsValid, .activeFactor
    );
    qios_host_model i_qios_host_model (
        .ref_clk, .rst, .chA(quadATrue), .chB(quadBTrue), .chI(indexTrueOut),
        .edgeCnt, .jumpCnt, .idxCnt
    );
    // Factors by first + 3*second + 9*third
    localparam int FAC [26] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 12, 14, 15, 16, 18, 20, 25,
        32, 50, 64, 80, 100, 128, 160, 256, 512};
    // 250 MHz clock
    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp)
        begin
            nErrors++;
            $display("mismatch at %0t: saw %0d expected %0d", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", totalChecks, nErrors);
        if (nErrors == 0 && totalChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Selects are static, so every setting needs its own reset
    task automatic boot(input logic [1:0] f, s, t, i);
        @(posedge ref_clk);
        modeSelectFirst <= f;
        modeSelectSecond <= s;
        modeSelectThird <= t;
        indexGatingSelect <= i;
        rawIndex <= 1'b0;
        opticalAngle <= '0;
        rst <= 1'b1;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (10) @(posedge ref_clk);
        #1;
    endtask
    // Advance the angle one step a cycle, counting high samples
    task automatic step(input int n, output int hiA, output int hiAB, output int hiI);
        hiA = 0;
        hiAB = 0;
        hiI = 0;
        repeat (n)
        begin
            @(posedge ref_clk);
            opticalAngle <= opticalAngle + 11'h1;
            #1;
            hiA += int'(quadATrue);
            hiAB += int'(quadATrue & quadBTrue);
            hiI += int'(indexTrueOut);
        end
    endtask
    // Bounded wait for the next flip of the aux clock pin
    task automatic wait_flip(output int n);
        logic v;
        v = indexCompOut;
        n = 0;
        while (indexCompOut === v && n < 3000)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n >= 3000)
        begin
            check(0, 1);
            give_verdict();
        end
    endtask
    task automatic sc_table();
        for (int k = 0; k < 26; k++)
        begin
            boot(2'(k % 3), 2'((k / 3) % 3), 2'(k / 9), 2'h0);
            check(32'(activeFactor), FAC[k]);
            check(outputsValid, 1'b0);
        end
    endtask
    // Factor 4: exact edge, duty and overlap counts over one optical cycle
    task automatic sc_wave();
        int a, ab, ix, e0;
        boot(2'h0, 2'h1, 2'h0, 2'h0);
        step(256, a, ab, ix);
        check(outputsValid, 1'b1);
        e0 = edgeCnt;
        step(2048, a, ab, ix);
        check(edgeCnt - e0, 16);
        check(a, 1024);
        check(ab, 512);
        check(jumpCnt, 0);
    endtask
    // One optical cycle with the index high, count index-high cycles
    task automatic sc_index(input logic [1:0] s, i, input int w);
        int a, ab, ix, t, i0;
        boot(2'h0, s, 2'h0, i);
        step(2048, a, ab, ix);
        i0 = idxCnt;
        @(posedge ref_clk);
        rawIndex <= 1'b1;
        step(2048, a, ab, ix);
        @(posedge ref_clk);
        rawIndex <= 1'b0;
        step(4, a, ab, t);
        check(ix + t, w);
        check(idxCnt - i0, 1);
    endtask
    task automatic sc_serial();
        int n;
        boot(2'h2, 2'h2, 2'h2, 2'h0);
        check(programmingActive, 1'b1);
        check({quadACompOeN, quadBCompOeN}, 2'h3);
        check({indexTrueOeN, indexCompOeN}, 2'h0);
        @(posedge ref_clk);
        serialDataOutFromEngine <= 1'b1;
        hostDin <= 1'b1;
        hostClk <= 1'b1;
        repeat (6) @(posedge ref_clk);
        #1;
        check(indexTrueOut, 1'b1);
        check({serialDataInToEngine, serialClockToEngine}, 2'h3);
        wait_flip(n);
        wait_flip(n);
        check(n, 1250);
        @(posedge ref_clk);
        hostClk <= 1'b0;
        indexGatingSelect <= 2'h1;
        repeat (10) @(posedge ref_clk);
        #1;
        check(programmingActive, 1'b0);
        check(32'(activeFactor), 5);
    endtask
    initial
    begin
        sc_table();
        sc_wave();
        sc_index(2'h1, 2'h0, 128);
        sc_index(2'h1, 2'h1, 256);
        sc_index(2'h1, 2'h2, 512);
        sc_index(2'h0, 2'h2, 2048);
        sc_serial();
        give_verdict();
    end
endmodule
